// ===== common/mvc_map.svh
// Constant map of the majority voting comparator
`ifndef MVC_MAP_SVH
`define MVC_MAP_SVH

// State codes seen on state_code
`define MVC_CODE_RUN   4'h1
`define MVC_CODE_STOP  4'h2
`define MVC_CODE_SAFE  4'h3
`define MVC_CODE_ERROR 4'h4
`define MVC_CODE_RESET 4'h5
`define MVC_CODE_HOLD  4'h8
`define MVC_CODE_NONE  4'h0

// Diagnostic codes
`define MVC_DIAG_OK    2'h0
`define MVC_DIAG_UNDER 2'h1
`define MVC_DIAG_OVER  2'h2

// Diagnostic message text identifiers
`define MVC_TEXT_UNDER 16'h4098
`define MVC_TEXT_OVER  16'h4099

// Channel masks and agreement quorum per architecture
`define MVC_ACT_1OO2   5'h03
`define MVC_ACT_2OO3   5'h07
`define MVC_ACT_3OO5   5'h1f
`define MVC_NEED_1OO2  3'h2
`define MVC_NEED_2OO3  3'h2
`define MVC_NEED_3OO5  3'h3

// 16-bit output limits, low halves
`define MVC_S16_MAX    15'h7fff
`define MVC_U16_MAX    16'hffff

// Timing: one millisecond in ns, clock period in ns
`define MVC_MS_NS      1000000
`define MVC_CLK_NS     4

`endif

// ===== common/mvc_pkg.sv
// Types of the majority voting comparator
`default_nettype none
package mvc_pkg;
  typedef enum logic [1:0] {ARCH_1OO2, ARCH_2OO3, ARCH_3OO5} mvc_arch_e;
  typedef enum logic [2:0] {ST_STOP, ST_RUN, ST_HOLD, ST_SAFE, ST_ERROR, ST_RESET} mvc_state_e;
endpackage
`default_nettype wire

// ===== src/mvc_ms_tick.sv
// Millisecond enable divider for the grace timer
`default_nettype none
module mvc_ms_tick #(
  parameter int unsigned CYC = 250000
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic clr,
  output logic      tick
);
  localparam int unsigned CW = (CYC > 1) ? $clog2(CYC) : 1;
  localparam logic [CW-1:0] LAST = CW'(CYC - 1);

  logic [CW-1:0] cnt_r;
  wire           wrap = (cnt_r == LAST);

  always_ff @(posedge mclk) begin
    if (!rst_n || clr) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else begin
      cnt_r <= wrap ? '0 : cnt_r + 1'b1;
      tick  <= wrap;
    end
  end
endmodule
`default_nettype wire

// ===== src/mvc_vote.sv
// Pairwise agreement and majority selection over five channels
`default_nettype none
`include "mvc_map.svh"
module mvc_vote import mvc_pkg::*; #(
  parameter int W = 32
) (
  input  wire logic [4:0][W-1:0] chans,
  input  wire logic              in_signed,
  input  wire logic              in_16bit,
  input  wire mvc_arch_e         arch_sel,
  input  wire logic [W-1:0]      spread,
  output logic                   enough,
  output logic                   pair12_agree,
  output logic signed [W:0]      sel_val
);
  function automatic logic signed [W:0] norm(input logic [W-1:0] x, input logic sgn,
                                             input logic h16);
    logic [W:0] r;
    if (h16)
      r = sgn ? {{(W-15){x[15]}}, x[15:0]} : {{(W-15){1'b0}}, x[15:0]};
    else
      r = sgn ? {x[W-1], x} : {1'b0, x};
    return signed'(r);
  endfunction

  logic signed [4:0][W:0] nv;
  logic [4:0][4:0]        agree;
  logic [4:0]             ok;
  logic [4:0]             act;
  logic [2:0]             need;

  assign act  = (arch_sel == ARCH_1OO2) ? `MVC_ACT_1OO2 :
                (arch_sel == ARCH_2OO3) ? `MVC_ACT_2OO3 : `MVC_ACT_3OO5;
  assign need = (arch_sel == ARCH_1OO2) ? `MVC_NEED_1OO2 :
                (arch_sel == ARCH_2OO3) ? `MVC_NEED_2OO3 : `MVC_NEED_3OO5;

  for (genvar i = 0; i < 5; i++) begin : g_ch
    assign nv[i] = norm(chans[i], in_signed, in_16bit);
    for (genvar j = 0; j < 5; j++) begin : g_pair
      wire [W+1:0] d   = {nv[i][W], nv[i]} - {nv[j][W], nv[j]};
      wire [W+1:0] mag = d[W+1] ? (~d + 1'b1) : d;
      assign agree[i][j] = (mag <= {2'b00, spread});
    end
    assign ok[i] = act[i] && (3'($countones(agree[i] & act)) >= need);
  end

  assign enough       = |ok;
  assign pair12_agree = agree[0][1];

  always_comb begin
    sel_val = '0;
    for (int k = 4; k >= 0; k--) begin
      if (ok[k]) sel_val = nv[k];
    end
  end
endmodule
`default_nettype wire

// ===== src/mvc_compare.sv
// Majority voting comparator with grace timer and range check
//
// Function
// - Compare two to five analog channels by value and time tolerance.
// - Inputs signed or unsigned, 16 or 32 bits; output type configured separately.
// - Two-channel mode: both must agree, else output and valid are zero.
// - Three-channel mode: two agreeing values needed, else output cleared.
// - Five-channel mode: three agreeing values needed, else output cleared.
// - Configured value spread and grace time in milliseconds.
// - Valid output is one on positive result, zero on negative.
// - Output takes lowest-numbered channel meeting the agreement criteria.
// - Output range violation gives error state, error one, outputs zero.
// - Diagnostic code 0 correct, 1 underflow, 2 overflow.
// - Message id 4098 underflow, 4099 overflow, with block, value, limit.
// - Agreement gives run state 1, valid one, lowest agreeing value.
// - Run enable low gives stop state 2; value, valid, error and diag code zero.
// - Lost agreement starts grace timer; state 8 holds valid and value.
// - Range error gives state 4, error one, message to group unit.
// - Error gone and acknowledge high gives reset state 5, outputs zero.
`default_nettype none
`include "mvc_map.svh"
module mvc_compare import mvc_pkg::*; #(
  parameter int          W      = 32,
  parameter int          GW     = 16,
  parameter int unsigned MS_CYC = `MVC_MS_NS / `MVC_CLK_NS
) (
  input  wire logic          mclk,
  input  wire logic          rst_n,
  input  wire logic          block_run_enable,
  input  wire logic          group_error_ack,
  input  wire mvc_arch_e     arch_sel,
  input  wire logic          in_signed,
  input  wire logic          in_16bit,
  input  wire logic          out_signed,
  input  wire logic          out_16bit,
  input  wire logic [W-1:0]  max_value_spread,
  input  wire logic [GW-1:0] mismatch_grace_time,
  input  wire logic [15:0]   block_number,
  input  wire logic [W-1:0]  compare_input_1,
  input  wire logic [W-1:0]  compare_input_2,
  input  wire logic [W-1:0]  compare_input_3,
  input  wire logic [W-1:0]  compare_input_4,
  input  wire logic [W-1:0]  compare_input_5,
  output logic [W-1:0]       voted_value_out,
  output logic               agreement_valid,
  output logic               error_out,
  output logic [1:0]         diag_code,
  output logic [3:0]         state_code,
  output logic               diag_msg_valid,
  output logic [15:0]        diag_msg_text_id,
  output logic [15:0]        diag_msg_block,
  output logic [W-1:0]       diag_msg_value,
  output logic [W-1:0]       diag_msg_limit
);
  // Output limits at W+1 bits
  localparam logic signed [W:0] S16_MIN = {{(W-14){1'b1}}, 15'h0000};
  localparam logic signed [W:0] S16_MAX = {{(W-14){1'b0}}, `MVC_S16_MAX};
  localparam logic signed [W:0] U16_MAX = {{(W-15){1'b0}}, `MVC_U16_MAX};
  localparam logic signed [W:0] SW_MIN  = {2'b11, {(W-1){1'b0}}};
  localparam logic signed [W:0] SW_MAX  = {2'b00, {(W-1){1'b1}}};
  localparam logic signed [W:0] UW_MAX  = {1'b0, {W{1'b1}}};

  function automatic logic [3:0] code_of(input mvc_state_e s);
    unique case (s)
      ST_STOP:  return `MVC_CODE_STOP;
      ST_RUN:   return `MVC_CODE_RUN;
      ST_HOLD:  return `MVC_CODE_HOLD;
      ST_SAFE:  return `MVC_CODE_SAFE;
      ST_ERROR: return `MVC_CODE_ERROR;
      ST_RESET: return `MVC_CODE_RESET;
      default:  return `MVC_CODE_NONE;
    endcase
  endfunction

  mvc_state_e      state_r;
  mvc_state_e      state_nxt;
  mvc_state_e      eval_st;
  logic [GW-1:0]   grace_r;
  logic [GW-1:0]   grace_nxt;
  logic            enough;
  logic            pair12_agree;
  logic            tick;
  logic signed [W:0] sel_val;

  // Voting over the configured channels
  mvc_vote #(
    .W (W)
  ) u_vote (
    .chans        ({compare_input_5, compare_input_4, compare_input_3,
                    compare_input_2, compare_input_1}),
    .in_signed    (in_signed),
    .in_16bit     (in_16bit),
    .arch_sel     (arch_sel),
    .spread       (max_value_spread),
    .enough       (enough),
    .pair12_agree (pair12_agree),
    .sel_val      (sel_val)
  );

  // Millisecond enable, restarted on entry to the hold state
  mvc_ms_tick #(
    .CYC (MS_CYC)
  ) u_tick (
    .mclk  (mclk),
    .rst_n (rst_n),
    .clr   (state_r != ST_HOLD),
    .tick  (tick)
  );

  // Range check of the selected value against the output type
  wire logic signed [W:0] lim_lo = !out_signed ? '0 : (out_16bit ? S16_MIN : SW_MIN);
  wire logic signed [W:0] lim_hi = out_16bit ? (out_signed ? S16_MAX : U16_MAX)
                                             : (out_signed ? SW_MAX : UW_MAX);
  wire logic under    = (sel_val < lim_lo);
  wire logic over     = (sel_val > lim_hi);
  wire logic err_pend = block_run_enable && enough && (under || over);

  // Decision used from every operating state
  wire logic grace_zero = (mismatch_grace_time == '0);
  always_comb begin
    if (!block_run_enable)
      eval_st = ST_STOP;
    else if (enough)
      eval_st = err_pend ? ST_ERROR : ST_RUN;
    else if (state_r == ST_RUN && !grace_zero)
      eval_st = ST_HOLD;
    else if (state_r == ST_HOLD && grace_r != '0)
      eval_st = ST_HOLD;
    else
      eval_st = ST_SAFE;
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_ERROR: if (!err_pend && group_error_ack) state_nxt = ST_RESET;
      ST_RESET: if (!group_error_ack) state_nxt = eval_st;
      ST_STOP, ST_RUN, ST_HOLD, ST_SAFE: state_nxt = eval_st;
    endcase
  end

  // Grace timer in milliseconds
  wire logic grace_load = (state_r == ST_RUN) && (state_nxt == ST_HOLD);
  wire logic grace_dec  = (state_r == ST_HOLD) && tick && (grace_r != '0);
  assign grace_nxt = grace_load ? mismatch_grace_time :
                     grace_dec  ? grace_r - 1'b1 : grace_r;

  // Output next values
  wire logic         enter_err = (state_nxt == ST_ERROR) && (state_r != ST_ERROR);
  wire logic         valid_nxt = (state_nxt == ST_RUN) || (state_nxt == ST_HOLD);
  wire logic [W-1:0] value_nxt = (state_nxt == ST_RUN)  ? sel_val[W-1:0] :
                                 (state_nxt == ST_HOLD) ? voted_value_out : '0;
  wire logic [1:0]   diag_nxt  = enter_err ? (under ? `MVC_DIAG_UNDER : `MVC_DIAG_OVER) :
                                 (state_nxt == ST_ERROR) ? diag_code : `MVC_DIAG_OK;
  wire logic [15:0]  text_nxt  = under ? `MVC_TEXT_UNDER : `MVC_TEXT_OVER;
  wire logic [W-1:0] limit_nxt = under ? lim_lo[W-1:0] : lim_hi[W-1:0];

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_r         <= ST_STOP;
      grace_r         <= '0;
      voted_value_out <= '0;
      agreement_valid <= 1'b0;
      error_out       <= 1'b0;
      diag_code       <= `MVC_DIAG_OK;
      state_code      <= `MVC_CODE_STOP;
    end else begin
      state_r         <= state_nxt;
      grace_r         <= grace_nxt;
      voted_value_out <= value_nxt;
      agreement_valid <= valid_nxt;
      error_out       <= (state_nxt == ST_ERROR);
      diag_code       <= diag_nxt;
      state_code      <= code_of(state_nxt);
    end
  end

  // Diagnostic message to the group unit, one cycle per error entry
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      diag_msg_valid   <= 1'b0;
      diag_msg_text_id <= '0;
      diag_msg_block   <= '0;
      diag_msg_value   <= '0;
      diag_msg_limit   <= '0;
    end else begin
      diag_msg_valid <= enter_err;
      if (enter_err) begin
        diag_msg_text_id <= text_nxt;
        diag_msg_block   <= block_number;
        diag_msg_value   <= sel_val[W-1:0];
        diag_msg_limit   <= limit_nxt;
      end
    end
  end

  // Checks
  wire logic normal_st = (state_r == ST_STOP) || (state_r == ST_RUN) ||
                         (state_r == ST_HOLD) || (state_r == ST_SAFE);

  property p_valid_states;
    @(posedge mclk) disable iff (!rst_n)
      agreement_valid == (state_code == `MVC_CODE_RUN || state_code == `MVC_CODE_HOLD);
  endproperty
  a_valid_states: assert property (p_valid_states)
    else $error("valid does not match state code");

  property p_stop;
    @(posedge mclk) disable iff (!rst_n)
      (normal_st && !block_run_enable) |=>
        (state_code == `MVC_CODE_STOP && !error_out && !agreement_valid
         && voted_value_out == '0);
  endproperty
  a_stop: assert property (p_stop)
    else $error("run enable low did not stop the block");

  property p_run_value;
    @(posedge mclk) disable iff (!rst_n)
      (normal_st && block_run_enable && enough && !under && !over) |=>
        (state_code == `MVC_CODE_RUN && voted_value_out == $past(sel_val[W-1:0]));
  endproperty
  a_run_value: assert property (p_run_value)
    else $error("agreeing value not passed to output");

  property p_1oo2;
    @(posedge mclk) disable iff (!rst_n)
      (arch_sel == ARCH_1OO2) |-> (enough == pair12_agree);
  endproperty
  a_1oo2: assert property (p_1oo2)
    else $error("two-channel agreement wrong");

  property p_hold;
    @(posedge mclk) disable iff (!rst_n)
      (state_r == ST_RUN && block_run_enable && !enough && !grace_zero) |=>
        (state_code == `MVC_CODE_HOLD && agreement_valid && !error_out
         && grace_r == $past(mismatch_grace_time)
         && voted_value_out == $past(voted_value_out)) ##1
        (state_code != `MVC_CODE_HOLD || $stable(voted_value_out));
  endproperty
  a_hold: assert property (p_hold)
    else $error("hold state not entered or value changed");

  property p_safe;
    @(posedge mclk) disable iff (!rst_n)
      (state_r == ST_HOLD && grace_r == '0 && block_run_enable && !enough) |=>
        (state_code == `MVC_CODE_SAFE && !agreement_valid && voted_value_out == '0);
  endproperty
  a_safe: assert property (p_safe)
    else $error("expired grace did not reach safe state");

  property p_err;
    @(posedge mclk) disable iff (!rst_n)
      (normal_st && err_pend) |=>
        (error_out && state_code == `MVC_CODE_ERROR && diag_msg_valid
         && !agreement_valid && voted_value_out == '0) ##1 !diag_msg_valid;
  endproperty
  a_err: assert property (p_err)
    else $error("range error not handled");

  property p_diag;
    @(posedge mclk) disable iff (!rst_n)
      diag_msg_valid |->
        ((diag_code == `MVC_DIAG_UNDER && diag_msg_text_id == `MVC_TEXT_UNDER) ||
         (diag_code == `MVC_DIAG_OVER && diag_msg_text_id == `MVC_TEXT_OVER));
  endproperty
  a_diag: assert property (p_diag)
    else $error("diagnostic code and message disagree");

  property p_reset;
    @(posedge mclk) disable iff (!rst_n)
      (state_r == ST_ERROR && !err_pend && group_error_ack) |=>
        (state_code == `MVC_CODE_RESET && !error_out && !agreement_valid
         && voted_value_out == '0 && diag_code == `MVC_DIAG_OK);
  endproperty
  a_reset: assert property (p_reset)
    else $error("acknowledge did not reach reset state");

  property p_diag_hold;
    @(posedge mclk) disable iff (!rst_n)
      (state_r == ST_ERROR && !group_error_ack) |=>
        (state_code == `MVC_CODE_ERROR && error_out && $stable(diag_code));
  endproperty
  a_diag_hold: assert property (p_diag_hold)
    else $error("error state left without acknowledge");

  property p_diag_ok;
    @(posedge mclk) disable iff (!rst_n)
      (state_code != `MVC_CODE_ERROR) |-> (diag_code == `MVC_DIAG_OK && !error_out);
  endproperty
  a_diag_ok: assert property (p_diag_ok)
    else $error("diagnostic code set outside the error state");

  property p_msg_fields;
    @(posedge mclk) disable iff (!rst_n)
      enter_err |=>
        (diag_msg_valid && diag_msg_block == $past(block_number)
         && diag_msg_value == $past(sel_val[W-1:0]));
  endproperty
  a_msg_fields: assert property (p_msg_fields)
    else $error("diagnostic message fields wrong");

  property p_ack_reset_stay;
    @(posedge mclk) disable iff (!rst_n)
      (state_r == ST_RESET && group_error_ack) |=>
        (state_code == `MVC_CODE_RESET && !agreement_valid && !error_out);
  endproperty
  a_ack_reset_stay: assert property (p_ack_reset_stay)
    else $error("reset state left while acknowledge high");

  property p_grace_down;
    @(posedge mclk) disable iff (!rst_n)
      (state_r == ST_HOLD && state_nxt == ST_HOLD) |=> (grace_r <= $past(grace_r));
  endproperty
  a_grace_down: assert property (p_grace_down)
    else $error("grace timer counted up while holding");

  property p_zero_states;
    @(posedge mclk) disable iff (!rst_n)
      (state_code == `MVC_CODE_SAFE || state_code == `MVC_CODE_STOP
       || state_code == `MVC_CODE_RESET) |->
        (!agreement_valid && !error_out && voted_value_out == '0);
  endproperty
  a_zero_states: assert property (p_zero_states)
    else $error("outputs not cleared in a stop, safe or reset state");

  property p_first_chan;
    @(posedge mclk) disable iff (!rst_n)
      (normal_st && block_run_enable && arch_sel == ARCH_1OO2 && enough && !in_16bit
       && !under && !over) |=> (voted_value_out == $past(compare_input_1));
  endproperty
  a_first_chan: assert property (p_first_chan)
    else $error("two-channel vote did not pass the first channel");

  c_run:   cover property (@(posedge mclk) disable iff (!rst_n)
                           state_code == `MVC_CODE_RUN);
  c_hold:  cover property (@(posedge mclk) disable iff (!rst_n)
                           state_r == ST_HOLD ##1 state_r == ST_SAFE);
  c_err:   cover property (@(posedge mclk) disable iff (!rst_n)
                           diag_msg_valid);
  c_reset: cover property (@(posedge mclk) disable iff (!rst_n)
                           state_r == ST_RESET ##1 state_r == ST_RUN);
  c_under: cover property (@(posedge mclk) disable iff (!rst_n)
                           diag_msg_valid && diag_code == `MVC_DIAG_UNDER);
endmodule
`default_nettype wire

// ===== bench/mvc_group_model.sv
// Group unit model: drives the error acknowledge and logs diag messages
`default_nettype none
module mvc_group_model (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        ack_req,
  input  wire logic        diag_msg_valid,
  input  wire logic [15:0] diag_msg_text_id,
  output logic             group_error_ack,
  output logic [15:0]      last_id,
  output int               msg_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  // Acknowledge follows the request one cycle late, like a real group unit
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      group_error_ack <= 1'b0;
      last_id         <= 16'h0;
      msg_cnt         <= 0;
    end else begin
      group_error_ack <= ack_req;
      if (diag_msg_valid) begin
        last_id <= diag_msg_text_id;
        msg_cnt <= msg_cnt + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== bench/mvc_compare_tb.sv
// Self-checking bench of the majority voting comparator
`default_nettype none
`include "mvc_map.svh"
module mvc_compare_tb import mvc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    mvc_arch_e        a;
    logic             sg;
    logic             h;
    logic [31:0]      sp;
    logic [0:4][31:0] v;
    logic             ok;
    logic [31:0]      ev;
  } mvc_row_s;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        run = 1'b0;
  logic        ack_req = 1'b0;
  mvc_arch_e   arch = ARCH_1OO2;
  logic        in_sg = 1'b0;
  logic        in_h = 1'b0;
  logic        out_sg = 1'b0;
  logic        out_h = 1'b0;
  logic [31:0] spread = 32'h0;
  logic [15:0] grace = 16'h0;
  logic [31:0] ci [5] = '{default: 32'h0};
  logic [31:0] vout, mval, mlim;
  logic        vld, err, gack, mvalid;
  logic [1:0]  dcode;
  logic [3:0]  st;
  logic [15:0] mid, mblk, last_id;
  int          msg_cnt;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          n;
  mvc_row_s    rows [9];

  always #2 mclk = ~mclk;

  mvc_compare #(.MS_CYC(4)) DUT (
    .mclk(mclk), .rst_n(rst_n), .block_run_enable(run), .group_error_ack(gack),
    .arch_sel(arch), .in_signed(in_sg), .in_16bit(in_h), .out_signed(out_sg),
    .out_16bit(out_h), .max_value_spread(spread), .mismatch_grace_time(grace),
    .block_number(16'h00a5), .compare_input_1(ci[0]), .compare_input_2(ci[1]),
    .compare_input_3(ci[2]), .compare_input_4(ci[3]), .compare_input_5(ci[4]),
    .voted_value_out(vout), .agreement_valid(vld), .error_out(err), .diag_code(dcode),
    .state_code(st), .diag_msg_valid(mvalid), .diag_msg_text_id(mid),
    .diag_msg_block(mblk), .diag_msg_value(mval), .diag_msg_limit(mlim));

  mvc_group_model u_group (
    .mclk(mclk), .rst_n(rst_n), .ack_req(ack_req), .diag_msg_valid(mvalid),
    .diag_msg_text_id(mid), .group_error_ack(gack), .last_id(last_id), .msg_cnt(msg_cnt));

  task automatic report_and_stop();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask

  task automatic chk_out(input logic [3:0] s, input logic [31:0] v, input logic va,
                         input logic e);
    chk("state_code", 32'(s), 32'(st));
    chk("voted_value_out", v, vout);
    chk("agreement_valid", 32'(va), 32'(vld));
    chk("error_out", 32'(e), 32'(err));
  endtask

  task automatic smp();
    @(posedge mclk);
    #1;
  endtask

  task automatic wait_st(input logic [3:0] s, input int lim, output int cyc);
    cyc = 0;
    while (st !== s) begin
      if (cyc == lim) begin
        $display("[ERR] state_code expected %h seen %h", s, st);
        error_cnt++;
        report_and_stop();
      end
      smp();
      cyc++;
    end
  endtask

  task automatic set_row(input int i);
    @(posedge mclk);
    run <= 1'b1;
    arch <= rows[i].a;
    in_sg <= rows[i].sg;
    out_sg <= rows[i].sg;
    in_h <= rows[i].h;
    out_h <= rows[i].h;
    spread <= rows[i].sp;
    for (int k = 0; k < 5; k++) begin
      ci[k] <= rows[i].v[k];
    end
  endtask

  // Inputs back in range with acknowledge held, then release
  task automatic clear_err();
    @(posedge mclk);
    ack_req <= 1'b1;
    ci[0] <= 32'h10;
    ci[1] <= 32'h10;
    wait_st(`MVC_CODE_RESET, 8, n);
    chk_out(`MVC_CODE_RESET, 32'h0, 1'b0, 1'b0);
    chk("diag_code", 32'h0, 32'(dcode));
    @(posedge mclk);
    ack_req <= 1'b0;
    wait_st(`MVC_CODE_RUN, 8, n);
    chk_out(`MVC_CODE_RUN, 32'h10, 1'b1, 1'b0);
  endtask

  initial begin
    rows[0] = '{ARCH_1OO2, 1'b0, 1'b0, 32'h5, {32'h64, 32'h69, 32'h0, 32'h0, 32'h0},
                1'b1, 32'h64};
    rows[1] = '{ARCH_1OO2, 1'b0, 1'b0, 32'h5, {32'h64, 32'h6a, 32'h0, 32'h0, 32'h0},
                1'b0, 32'h0};
    rows[2] = '{ARCH_2OO3, 1'b0, 1'b0, 32'h2, {32'ha, 32'h32, 32'h34, 32'h0, 32'h0},
                1'b1, 32'h32};
    rows[3] = '{ARCH_2OO3, 1'b0, 1'b0, 32'h2, {32'ha, 32'h32, 32'h5a, 32'h5a, 32'h5a},
                1'b0, 32'h0};
    rows[4] = '{ARCH_3OO5, 1'b0, 1'b0, 32'h2, {32'h1, 32'h64, 32'h7, 32'h65, 32'h66},
                1'b1, 32'h64};
    rows[5] = '{ARCH_3OO5, 1'b0, 1'b0, 32'h2, {32'h1, 32'h64, 32'h7, 32'h65, 32'h32},
                1'b0, 32'h0};
    rows[6] = '{ARCH_3OO5, 1'b1, 1'b0, 32'h2, {32'hffff_fffb, 32'hffff_fffd, 32'h7000,
                32'hffff_fffc, 32'h9}, 1'b1, 32'hffff_fffb};
    rows[7] = '{ARCH_2OO3, 1'b1, 1'b1, 32'h1, {32'h1234_ffff, 32'hfffe, 32'h55, 32'h0,
                32'h0}, 1'b1, 32'hffff_ffff};
    rows[8] = '{ARCH_1OO2, 1'b0, 1'b1, 32'h2, {32'hffff_0010, 32'h12, 32'h0, 32'h0, 32'h0},
                1'b1, 32'h10};
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    smp();
    chk_out(`MVC_CODE_STOP, 32'h0, 1'b0, 1'b0);
    foreach (rows[i]) begin
      set_row(i);
      smp();
      chk_out(rows[i].ok ? `MVC_CODE_RUN : `MVC_CODE_SAFE, rows[i].ev, rows[i].ok,
              1'b0);
    end
    // Grace window of 2 ms at 4 cycles per ms
    set_row(0);
    grace <= 16'h2;
    smp();
    chk_out(`MVC_CODE_RUN, 32'h64, 1'b1, 1'b0);
    @(posedge mclk);
    ci[1] <= 32'h6a;
    smp();
    chk_out(`MVC_CODE_HOLD, 32'h64, 1'b1, 1'b0);
    wait_st(`MVC_CODE_SAFE, 30, n);
    chk("grace_cycles", 32'h1, 32'(n >= 8 && n <= 11));
    chk_out(`MVC_CODE_SAFE, 32'h0, 1'b0, 1'b0);
    // Overflow of a signed 16-bit output
    @(posedge mclk);
    ci[1] <= 32'h64;
    out_sg <= 1'b1;
    out_h <= 1'b1;
    smp();
    chk_out(`MVC_CODE_RUN, 32'h64, 1'b1, 1'b0);
    @(posedge mclk);
    ci[0] <= 32'h1_0000;
    ci[1] <= 32'h1_0000;
    smp();
    chk_out(`MVC_CODE_ERROR, 32'h0, 1'b0, 1'b1);
    chk("diag_code", 32'h2, 32'(dcode));
    chk("diag_msg_valid", 32'h1, 32'(mvalid));
    chk("diag_msg_text_id", 32'h4099, 32'(mid));
    chk("diag_msg_block", 32'h00a5, 32'(mblk));
    chk("diag_msg_value", 32'h1_0000, mval);
    chk("diag_msg_limit", 32'h7fff, mlim);
    smp();
    chk("diag_msg_valid", 32'h0, 32'(mvalid));
    @(posedge mclk);
    ack_req <= 1'b1;
    repeat (3) smp();
    chk("state_code", 32'(`MVC_CODE_ERROR), 32'(st));
    clear_err();
    // Underflow of an unsigned 32-bit output
    @(posedge mclk);
    in_sg <= 1'b1;
    out_sg <= 1'b0;
    out_h <= 1'b0;
    ci[0] <= 32'hffff_fffb;
    ci[1] <= 32'hffff_fffb;
    smp();
    chk_out(`MVC_CODE_ERROR, 32'h0, 1'b0, 1'b1);
    chk("diag_code", 32'h1, 32'(dcode));
    chk("diag_msg_text_id", 32'h4098, 32'(mid));
    chk("diag_msg_value", 32'hffff_fffb, mval);
    chk("diag_msg_limit", 32'h0, mlim);
    clear_err();
    chk("msg_cnt", 32'h2, 32'(msg_cnt));
    chk("last_id", 32'h4098, 32'(last_id));
    // Reset in mid-run clears the message fields; agreement resumes at once
    @(posedge mclk);
    rst_n <= 1'b0;
    smp();
    chk_out(`MVC_CODE_STOP, 32'h0, 1'b0, 1'b0);
    chk("diag_msg_text_id", 32'h0, 32'(mid));
    @(posedge mclk);
    rst_n <= 1'b1;
    smp();
    chk_out(`MVC_CODE_RUN, 32'h10, 1'b1, 1'b0);
    @(posedge mclk);
    run <= 1'b0;
    smp();
    chk_out(`MVC_CODE_STOP, 32'h0, 1'b0, 1'b0);
    report_and_stop();
  end
endmodule
`default_nettype wire
